// ==== vic_top.sv ====
// vectored interrupt controller: request latching, masking, priority, vectoring
// Operation
// - eight request inputs, each with its own vector
// - fixed or rotating priority chosen by software
// - polling can replace vectored acknowledge
// - one mask bit per input blocks it
// - mask loads whole byte or single bits
// - short one-shot and steady requests both caught
// - narrow noise glitches never set requests
// - filtered request latched until acknowledged or cleared
// - unmasked latched requests raise group interrupt
// - priority resolved when acknowledge arrives
// - winning level's response byte driven on acknowledge
// - mode 0 byte programmable to any restart
// - mode 0 should hold single-byte instructions only
// - mode 2 byte forms low pointer byte
// - mode 2 vector bit zero always zero
// - setup by command writes, state by status
// - fixed priority: level 7 highest, 0 lowest
// - rotating: last serviced lowest, no nesting
// - acknowledge clears request, sets in-service unless auto-clear
// - poll mode silences group output, rest continues; the code also ignores acknowledge and drops the in-service fence
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
module vic_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // backplane request lines, active low
    input wire logic [7:0] vi_n_in,
    // processor side
    input wire logic ack_in,
    output logic int_n_out,
    output vic_pkg::vic_vec_s vec_out
);
    localparam int N = vic_pkg::NLVL;

    // reset release
    logic [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // registers
    logic [vic_pkg::MODE_W-1:0] mode_r;
    logic [7:0] mask_bits_r;
    logic [7:0] request_latch_bits_r;
    logic [7:0] in_service_bits_r;
    logic [7:0] auto_clear_bits_r;
    logic [7:0] resp_r [N];
    logic [2:0] last_r;
    logic [2:0] sel_r;
    vic_pkg::vic_ack_e ack_st_r;
    vic_pkg::vic_vec_s vec_r;

    // mode fields
    wire priority_order_select = mode_r[vic_pkg::MODE_ROT];
    wire common_vec = mode_r[vic_pkg::MODE_COMMON];
    wire poll_select_bit = mode_r[vic_pkg::MODE_POLL];
    wire armed = mode_r[vic_pkg::MODE_ARM];
    wire [1:0] cpu_mode = mode_r[vic_pkg::MODE_CPUM +: 2];

    // pin synchronisers and filters
    logic [7:0] vi_s1_r;
    logic [7:0] vi_s2_r;
    logic [7:0] hit;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            vi_s1_r <= 8'h00;
            vi_s2_r <= 8'h00;
        end else begin
            vi_s1_r <= ~vi_n_in;
            vi_s2_r <= vi_s1_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_filt
            vic_filter u_filt (
                .clk_in(clk_in),
                .rst_n_in(rst_n),
                .req_in(vi_s2_r[gi]),
                .hit_out(hit[gi])
            );
        end
    endgenerate

    // walk the circle downward from top, first set bit wins
    function automatic logic [3:0] pick(input logic [7:0] v, input logic [2:0] top);
        logic [3:0] r;
        logic [2:0] idx;
        r = 4'h0;
        for (int k = N - 1; k >= 0; k--) begin
            idx = top - 3'(k);
            if (v[idx]) begin
                r = {1'b1, idx};
            end
        end
        return r;
    endfunction

    // highest set bit; bit 3 of the result is clear when none is set
    function automatic logic [3:0] top_bit(input logic [7:0] v);
        return pick(v, 3'h7);
    endfunction

    // fence: fixed mode only passes levels above the highest in service
    logic [3:0] isr_top;
    logic [7:0] fence;
    assign isr_top = top_bit(in_service_bits_r);
    always_comb begin
        fence = 8'hff;
        for (int i = 0; i < N; i++) begin
            if (isr_top[3] && 3'(i) <= isr_top[2:0]) begin
                fence[i] = 1'b0;
            end
        end
        if (priority_order_select && isr_top[3]) begin
            fence = 8'h00;
        end
    end

    // poll mode bypasses fencing but keeps masking and priority
    wire [7:0] unmasked = request_latch_bits_r & ~mask_bits_r & {8{armed}};
    wire [7:0] pend = poll_select_bit ? unmasked : (unmasked & fence);
    // rotating start sits just below the last level serviced
    wire [2:0] top_lvl = priority_order_select ? last_r - 3'h1 : 3'h7;
    wire [3:0] best = pick(pend, top_lvl);
    wire group = best[3];

    assign int_n_out = !(group && !poll_select_bit);

    // acknowledge sequencing
    wire ack_take = (ack_st_r == vic_pkg::ACK_IDLE) && ack_in && !poll_select_bit;
    wire take_ok = ack_take && group;
    wire [2:0] take_lvl = best[2:0];
    wire [7:0] take_bit = 8'h01 << take_lvl;
    wire [7:0] raw_vec = resp_r[common_vec ? 3'h7 : take_lvl];
    wire [7:0] vec_byte = (cpu_mode == vic_pkg::CPU_MODE2) ? {raw_vec[7:1], 1'b0} : raw_vec;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ack_st_r <= vic_pkg::ACK_IDLE;
            sel_r <= 3'h0;
            vec_r <= '0;
        end else begin
            unique case (ack_st_r)
                vic_pkg::ACK_IDLE: begin
                    if (ack_take) begin
                        ack_st_r <= vic_pkg::ACK_DRIVE;
                        sel_r <= take_lvl;
                        vec_r <= {1'b1, vec_byte};
                    end
                end
                vic_pkg::ACK_DRIVE: begin
                    if (!ack_in) begin
                        ack_st_r <= vic_pkg::ACK_IDLE;
                        vec_r <= '0;
                    end
                end
            endcase
        end
    end

    assign vec_out = vec_r;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 3'h0;
        end else if (take_ok) begin
            last_r <= take_lvl;
        end
    end

    // apb decode
    wire wr = psel && penable && pwrite;
    wire rd_ok = psel && !pwrite;
    wire a_mode = paddr == vic_pkg::OFS_MODE;
    wire a_mask = paddr == vic_pkg::OFS_MASK;
    wire a_mset = paddr == vic_pkg::OFS_MASK_SET;
    wire a_mclr = paddr == vic_pkg::OFS_MASK_CLR;
    wire a_stat = paddr == vic_pkg::OFS_STATUS;
    wire a_req = paddr == vic_pkg::OFS_REQ;
    wire a_isr = paddr == vic_pkg::OFS_INSVC;
    wire a_acr = paddr == vic_pkg::OFS_AUTOCLR;
    wire a_resp = paddr >= vic_pkg::OFS_RESP && paddr <= vic_pkg::OFS_RESP_END
        && paddr[1:0] == 2'b00;
    wire [2:0] resp_idx = paddr[4:2];
    wire a_any = a_mode || a_mask || a_mset || a_mclr || a_stat || a_req || a_isr
        || a_acr || a_resp;
    // write-only mask set and clear strobes read back as zero
    wire [7:0] status = {group, 1'b0, priority_order_select, poll_select_bit, armed,
        ~best[2:0]};

    assign pready = 1'b1;
    assign pslverr = psel && penable && !a_any;

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_ok) begin
            if (a_mode) prdata = {22'h0, mode_r};
            if (a_mask) prdata = {24'h0, mask_bits_r};
            if (a_stat) prdata = {24'h0, status};
            if (a_req) prdata = {24'h0, request_latch_bits_r};
            if (a_isr) prdata = {24'h0, in_service_bits_r};
            if (a_acr) prdata = {24'h0, auto_clear_bits_r};
            if (a_resp) prdata = {24'h0, resp_r[resp_idx]};
        end
    end

    // command registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= vic_pkg::MODE_RST;
            mask_bits_r <= vic_pkg::MASK_RST;
            auto_clear_bits_r <= vic_pkg::AUTOCLR_RST;
        end else if (wr) begin
            if (a_mode) mode_r <= pwdata[vic_pkg::MODE_W-1:0];
            if (a_mask) mask_bits_r <= pwdata[7:0];
            if (a_mset) mask_bits_r <= mask_bits_r | pwdata[7:0];
            if (a_mclr) mask_bits_r <= mask_bits_r & ~pwdata[7:0];
            if (a_acr) auto_clear_bits_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                resp_r[i] <= vic_pkg::RESP_RST;
            end
        end else if (wr && a_resp) begin
            resp_r[resp_idx] <= pwdata[7:0];
        end
    end

    // request and in-service latches; new events win over clears
    wire [7:0] req_clr = (wr && a_req ? pwdata[7:0] : 8'h00) | (take_ok ? take_bit : 8'h00);
    wire [7:0] isr_clr = wr && a_isr ? pwdata[7:0] : 8'h00;
    wire [7:0] isr_set = take_ok ? (take_bit & ~auto_clear_bits_r) : 8'h00;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            request_latch_bits_r <= 8'h00;
            in_service_bits_r <= 8'h00;
        end else begin
            request_latch_bits_r <= (request_latch_bits_r & ~req_clr) | hit;
            in_service_bits_r <= (in_service_bits_r & ~isr_clr) | isr_set;
        end
    end
endmodule

// ==== vic_pkg.sv ====
// constants, types and register map of the vectored interrupt controller
package vic_pkg;
    localparam int NLVL = 8;
    localparam int CLK_MHZ = 10;
    // narrowest request pulse that is taken as real, in ns
    localparam int FILT_NS = 300;
    localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;

    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_MASK_SET = 8'h08;
    localparam logic [7:0] OFS_MASK_CLR = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_REQ = 8'h14;
    localparam logic [7:0] OFS_INSVC = 8'h18;
    localparam logic [7:0] OFS_AUTOCLR = 8'h1c;
    localparam logic [7:0] OFS_RESP = 8'h20;
    localparam logic [7:0] OFS_RESP_END = 8'h3c;

    // mode register fields
    localparam int MODE_ROT = 0;
    localparam int MODE_COMMON = 1;
    localparam int MODE_POLL = 2;
    localparam int MODE_ARM = 7;
    localparam int MODE_CPUM = 8;
    localparam int MODE_W = 10;
    localparam logic [9:0] MODE_RST = 10'h000;
    localparam logic [1:0] CPU_MODE2 = 2'h2;

    // status register fields
    localparam int ST_ARM = 3;
    localparam int ST_POLL = 4;
    localparam int ST_ROT = 5;
    localparam int ST_GROUP = 7;

    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] AUTOCLR_RST = 8'h00;
    localparam logic [7:0] RESP_RST = 8'h00;

    typedef struct packed {
        logic oe;
        logic [7:0] data;
    } vic_vec_s;

    typedef enum logic [0:0] {
        ACK_IDLE = 1'b0,
        ACK_DRIVE = 1'b1
    } vic_ack_e;
endpackage

// ==== vic_filter.sv ====
// noise filter and pulse catcher for one synchronised request line
`timescale 1ns/10ps
module vic_filter (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // request level, already synchronised, active high
    input wire logic req_in,
    // one-cycle pulse once the request has been stable long enough
    output logic hit_out
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic done_r;
    wire full = (cnt_r == 4'(vic_pkg::FILT_CYC - 1));

    // shorter spikes reset the count and never fire
    assign cnt_nxt = !req_in ? 4'h0 : (full ? cnt_r : cnt_r + 4'h1);
    assign hit_out = req_in && full && !done_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 4'h0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= req_in && (done_r || full);
        end
    end
endmodule

// ==== vic_top_properties.sv ====
// concurrent checks on the ports of the vectored interrupt controller
`timescale 1ns/10ps
module vic_top_properties (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] vi_n_in,
    input wire logic ack_in,
    input wire logic int_n_out,
    input wire vic_pkg::vic_vec_s vec_out
);
    logic [1:0] cpum_r;
    logic poll_r;
    wire mode_wr = psel && penable && pwrite && paddr == vic_pkg::OFS_MODE;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // shadow of the mode fields, since only the ports are visible here
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cpum_r <= 2'h0;
            poll_r <= 1'b0;
        end else if (mode_wr) begin
            cpum_r <= pwdata[9:8];
            poll_r <= pwdata[2];
        end
    end
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_SLVERR: assert property (psel && penable && paddr > 8'h3c |-> pslverr)
        else $error("unmapped access not refused");
    AST_RD_ZERO: assert property ((!psel || pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read");
    AST_RST_QUIET: assert property ($rose(nrst_in) |-> int_n_out [*3])
        else $error("group interrupt active after reset");
    AST_POLL_QUIET: assert property (poll_r |-> int_n_out)
        else $error("group interrupt in poll mode");
    AST_INT_HOLD: assert property (!int_n_out && !ack_in && !psel |=> !int_n_out)
        else $error("pending interrupt lost");
    AST_VEC_ONE: assert property ($rose(ack_in) && !int_n_out |=> vec_out.oe)
        else $error("no vector after acknowledge");
    AST_VEC_OFF: assert property (!ack_in |=> !vec_out.oe)
        else $error("vector driven without acknowledge");
    AST_VEC_HOLD: assert property (vec_out.oe && ack_in |=> $stable(vec_out.data))
        else $error("vector changed during acknowledge");
    AST_M2_LSB: assert property (vec_out.oe && cpum_r == 2'h2 |-> !vec_out.data[0])
        else $error("odd vector in mode 2");
    COV_ACK: cover property (vec_out.oe && ack_in);
    COV_ERR: cover property (pslverr);
    COV_POLL: cover property (poll_r && !vi_n_in[5]);
endmodule
bind vic_top vic_top_properties u_props (.clk_in(clk_in), .nrst_in(nrst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vi_n_in(vi_n_in), .ack_in(ack_in),
    .int_n_out(int_n_out), .vec_out(vec_out));

// ==== vic_cpu_model.sv ====
// processor model answering the group interrupt with acknowledge cycles
`timescale 1ns/10ps
module vic_cpu_model (
    // clock and control
    input wire logic clk_in,
    input wire logic en_in,
    // processor runs in fixed-call mode 1
    input wire logic im1_in,
    // controller side
    input wire logic int_n_in,
    input wire vic_pkg::vic_vec_s vec_in,
    output logic ack_out,
    // what was fetched
    output logic [7:0] vec_last_out,
    output int n_out,
    // location the processor calls for this interrupt
    output logic [15:0] call_out
);
    initial begin
        ack_out = 1'b0;
        vec_last_out = 8'h00;
        n_out = 0;
        call_out = 16'h0000;
        forever begin
            @(posedge clk_in);
            if (en_in && !int_n_in) begin
                // the running instruction ends first, taking a few cycles
                repeat ($urandom_range(3, 0)) @(posedge clk_in);
                ack_out <= 1'b1;
                repeat (2) @(posedge clk_in);
                // byte becomes restart code or low pointer half
                vec_last_out <= vec_in.data;
                // mode 1 ignores the byte; mode 0 restart picks one of eight slots
                call_out <= im1_in ? 16'h0066 : {10'h000, vec_in.data[5:3], 3'h0};
                n_out <= n_out + 1;
                ack_out <= 1'b0;
            end
        end
    end
endmodule

// ==== vic_top_test.sv ====
// self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
module vic_top_test;
    logic clk_in, nrst_in, psel, penable, pwrite, pready, pslverr, ack_in, int_n_out, en, er;
    logic [7:0] paddr, vi_n_in, vl, m, rb;
    logic [31:0] pwdata, prdata, rd;
    logic im1;
    logic [15:0] ca;
    vic_pkg::vic_vec_s vec_out;
    int nv, cyc;
    int fails = 0;
    int total_checks = 0;
    vic_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vi_n_in(vi_n_in), .ack_in(ack_in), .int_n_out(int_n_out),
        .vec_out(vec_out));
    vic_cpu_model i_cpu (.clk_in(clk_in), .en_in(en), .int_n_in(int_n_out), .vec_in(vec_out),
        .ack_out(ack_in), .vec_last_out(vl), .n_out(nv), .im1_in(im1), .call_out(ca));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // settled group output, a moment after the edge
    task automatic ci(input logic e);
        #1;
        chk({31'h0, int_n_out}, {31'h0, e});
    endtask
    task automatic pl(input logic [7:0] l, input int n);
        @(posedge clk_in);
        vi_n_in <= ~l;
        repeat (n) @(posedge clk_in);
        vi_n_in <= 8'hff;
        repeat (8) @(posedge clk_in);
    endtask
    task automatic ak(input logic [7:0] e);
        int n0;
        n0 = nv;
        en <= 1'b1;
        wait (nv != n0);
        en <= 1'b0;
        chk({24'h0, vl}, {24'h0, e});
        repeat (2) @(posedge clk_in);
    endtask
    function automatic logic [7:0] op(input int l);
        return 8'hc7 | 8'(l << 3);
    endfunction
    function automatic int top(input logic [7:0] v);
        top = 0;
        for (int i = 0; i < 8; i++) begin
            if (v[i])
                top = i;
        end
    endfunction
    initial begin
        {nrst_in, psel, penable, pwrite, en, im1, paddr, pwdata, vi_n_in} = {46'h0, 8'hff};
        void'($urandom(32'h3c1d2c27));
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        ci(1'b1);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'hff);
        rdc(8'h14, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (int l = 0; l < 8; l++) begin
            wr(8'h20 + 8'(4 * l), {24'h0, op(l)});
        end
        wr(8'h04, 32'h0);
        wr(8'h1c, 32'hff);
        wr(8'h00, 32'h80);
        for (int k = 0; k < 6; k++) begin
            m = (k == 0) ? 8'hff : 8'($urandom) | 8'h01;
            pl(m, vic_pkg::FILT_CYC);
            while (m != 8'h0) begin
                ak(op(top(m)));
                m[top(m)] = 1'b0;
            end
            ci(1'b1);
        end
        pl(8'h10, vic_pkg::FILT_CYC - 1);
        ci(1'b1);
        wr(8'h08, 32'h08);
        rdc(8'h04, 32'h08);
        pl(8'h08, vic_pkg::FILT_CYC);
        ci(1'b1);
        wr(8'h0c, 32'h08);
        ci(1'b0);
        ak(op(3));
        chk({16'h0, ca}, 32'h18);
        wr(8'h1c, 32'h0);
        pl(8'h04, vic_pkg::FILT_CYC);
        ak(op(2));
        rdc(8'h18, 32'h04);
        rdc(8'h14, 32'h0);
        pl(8'h02, vic_pkg::FILT_CYC);
        ci(1'b1);
        wr(8'h18, 32'h04);
        ak(op(1));
        wr(8'h18, 32'h02);
        wr(8'h1c, 32'hff);
        wr(8'h00, 32'h81);
        pl(8'h80, vic_pkg::FILT_CYC);
        ak(op(7));
        pl(8'ha0, vic_pkg::FILT_CYC);
        ak(op(5));
        ak(op(7));
        wr(8'h00, 32'h84);
        pl(8'h20, vic_pkg::FILT_CYC);
        ci(1'b1);
        rdc(8'h10, 32'h9a);
        wr(8'h14, 32'h20);
        rdc(8'h14, 32'h0);
        rb = 8'($urandom) | 8'h01;
        wr(8'h38, {24'h0, rb});
        wr(8'h00, 32'h280);
        pl(8'h40, vic_pkg::FILT_CYC);
        ak(rb & 8'hfe);
        // common vectoring: any level answers with the level 7 byte
        wr(8'h00, 32'h82);
        im1 <= 1'b1;
        pl(8'h08, vic_pkg::FILT_CYC);
        ak(op(7));
        chk({16'h0, ca}, 32'h66);
        results();
    end
endmodule
